// file: design/ssp_buf2.sv
/*
  Two-entry valid/ready buffer for received bytes. Assumes one clock domain
  and active-low asynchronous reset.
*/
`timescale 1ns/1ps
module ssp_buf2
  import ssp_pkg::*;
#(
  parameter int WIDTH = 8
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // Elaboration check: a zero-width word cannot be stored
  if (WIDTH < 1) $error("ssp_buf2 width must be positive");
  logic [WIDTH-1:0] mem [2]; // Storage words
  logic wp; // Write slot
  logic rp; // Read slot
  logic [1:0] cnt; // Words held
  logic push;
  logic pop;
  assign in_ready = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rp];
  ////////////////////////////////////////////////////////////////
  // Pointer and count tracking
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wp <= 1'b0;
      rp <= 1'b0;
      cnt <= 2'h0;
    end
    else
    begin
      if (push)
        wp <= ~wp;
      if (pop)
        rp <= ~rp;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end
  // Word storage, no reset needed since valid gates it
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp] <= in_data;
  end
endmodule

// file: design/ssp_cfg.svh
/*
  Constants for the synchronous serial port SPI master: mode codes, divider
  figures and reset values. Assumes inclusion by bare name, once per unit.
*/
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
`define SSP_MODE_M_DIV4 4'h0
`define SSP_MODE_M_DIV16 4'h1
`define SSP_MODE_M_DIV64 4'h2
`define SSP_MODE_M_TMR2 4'h3
`define SSP_MODE_S_SS 4'h4
`define SSP_MODE_S_NOSS 4'h5
`define SSP_MODE_I2C_S7 4'h6
`define SSP_MODE_I2C_S10 4'h7
`define SSP_MODE_I2C_MDIV 4'h8
`define SSP_MODE_RSVD9 4'h9
`define SSP_MODE_M_ADD 4'ha
`define SSP_MODE_I2C_FW 4'hb
`define SSP_MODE_RSVDC 4'hc
`define SSP_MODE_RSVDD 4'hd
`define SSP_MODE_I2C_S7SP 4'he
`define SSP_MODE_I2C_S10SP 4'hf
// Half-period counts in system clocks, half the divide ratio less one
`define SSP_HALF_DIV4 10'h001
`define SSP_HALF_DIV16 10'h007
`define SSP_HALF_DIV64 10'h01f
`define SSP_BITS 4'h8
`define SSP_BUF_RESET 8'h00
`endif

// file: design/ssp_pkg.sv
/*
  Types shared by the serial port files. Assumes ssp_cfg.svh alongside.
*/
package ssp_pkg;
  // Mode family decoded from the port mode code
  typedef enum logic [1:0] {SSP_FAM_MASTER, SSP_FAM_SLAVE, SSP_FAM_I2C, SSP_FAM_RSVD} ssp_fam_t;
  // Settings that steer the shifter
  typedef struct packed {
    logic [3:0] port_mode_code;
    logic clock_polarity_bit;
    logic clock_edge_bit;
    logic input_sample_phase_bit;
    logic [7:0] clock_divider_value;
  } ssp_cfg_t;
  // Status seen by software
  typedef struct packed {
    logic busy;
    logic rx_full;
    logic overflow;
    logic done_flag;
  } ssp_stat_t;
endpackage

// file: design/ssp_spi_master.sv
/*
  Synchronous serial port in SPI master role: mode decode, bit clock
  selection, eight-bit full-duplex shifter and receive buffering.
  Assumes sdi and tmr2_match come from outside and are synchronised here;
  the I2C and SPI slave engines live elsewhere and only see the decode.
*/
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_spi_master
  import ssp_pkg::*;
#(
  parameter int BUF_WIDTH = 8
)(
  input wire logic clk,
  input wire logic nrst,
  input wire ssp_cfg_t cfg,
  input wire logic enable,
  input wire logic wr_strobe,
  input wire logic [7:0] wr_data,
  output logic [7:0] xfer_buffer,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic wr_ready,
  output ssp_stat_t status,
  output ssp_fam_t mode_family,
  output logic slave_select_used,
  output logic i2c_ten_bit,
  output logic i2c_start_stop_irq,
  output logic i2c_master,
  output logic i2c_firmware,
  input wire logic tmr2_match,
  input wire logic sdi,
  output logic sck,
  output logic sdo,
  output logic sdo_oe,
  input wire logic sdo_out_disable
);
  // Elaboration check: the shifter is fixed at eight bits
  if (BUF_WIDTH != 8) $error("ssp_spi_master needs 8-bit buffer");
  ////////////////////////////////////////////////////////////////
  // Mode decode helper, used for family and master checks
  function automatic ssp_fam_t fam_of(input logic [3:0] m);
    unique case (m)
      `SSP_MODE_M_DIV4, `SSP_MODE_M_DIV16, `SSP_MODE_M_DIV64,
      `SSP_MODE_M_TMR2, `SSP_MODE_M_ADD: fam_of = SSP_FAM_MASTER;
      `SSP_MODE_S_SS, `SSP_MODE_S_NOSS: fam_of = SSP_FAM_SLAVE;
      `SSP_MODE_I2C_S7, `SSP_MODE_I2C_S10, `SSP_MODE_I2C_MDIV, `SSP_MODE_I2C_FW,
      `SSP_MODE_I2C_S7SP, `SSP_MODE_I2C_S10SP: fam_of = SSP_FAM_I2C;
      default: fam_of = SSP_FAM_RSVD;
    endcase
  endfunction
  typedef enum logic [1:0] {SSP_IDLE, SSP_LEAD, SSP_TRAIL} ssp_state_t;
  ssp_state_t state; // Shifter phase
  logic [7:0] shift_register; // Full-duplex shifter
  logic [3:0] bit_cnt; // Bits remaining
  logic [9:0] half_cnt; // Half-period timer
  logic [9:0] half_len; // Selected half-period
  logic sdi_s1, sdi_s2; // Input synchroniser
  logic tm_s1, tm_s2, tm_d; // Timer match synchroniser
  logic tm_toggle; // Timer match divided by two
  logic tm_toggle_d;
  logic tick; // Half-period elapsed
  logic is_master;
  logic sample_bit; // Captured input bit
  logic rx_push;
  logic rx_in_ready;
  logic [7:0] rx_byte;
  logic [7:0] rx_out;
  assign is_master = enable && (fam_of(cfg.port_mode_code) == SSP_FAM_MASTER);
  ////////////////////////////////////////////////////////////////
  // Mode family outputs for the other engines
  assign mode_family = fam_of(cfg.port_mode_code);
  assign slave_select_used = (cfg.port_mode_code == `SSP_MODE_S_SS);
  assign i2c_ten_bit = (cfg.port_mode_code == `SSP_MODE_I2C_S10) ||
                       (cfg.port_mode_code == `SSP_MODE_I2C_S10SP);
  assign i2c_start_stop_irq = (cfg.port_mode_code == `SSP_MODE_I2C_S7SP) ||
                              (cfg.port_mode_code == `SSP_MODE_I2C_S10SP);
  assign i2c_master = (cfg.port_mode_code == `SSP_MODE_I2C_MDIV);
  assign i2c_firmware = (cfg.port_mode_code == `SSP_MODE_I2C_FW);
  ////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for pins and timer match
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
      tm_s1 <= 1'b0;
      tm_s2 <= 1'b0;
      tm_d <= 1'b0;
    end
    else
    begin
      sdi_s1 <= sdi;
      sdi_s2 <= sdi_s1;
      tm_s1 <= tmr2_match;
      tm_s2 <= tm_s1;
      tm_d <= tm_s2;
    end
  end
  // Timer match halved: each half period is one match
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tm_toggle <= 1'b0;
      tm_toggle_d <= 1'b0;
    end
    else
    begin
      if (tm_s2 && !tm_d)
        tm_toggle <= ~tm_toggle;
      tm_toggle_d <= tm_toggle;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Bit clock selection; divider value zero is left to software
  always_comb
  begin
    half_len = `SSP_HALF_DIV4;
    unique case (cfg.port_mode_code)
      `SSP_MODE_M_DIV16: half_len = `SSP_HALF_DIV16;
      `SSP_MODE_M_DIV64: half_len = `SSP_HALF_DIV64;
      // Half of 4*(n+1) clocks is 2n+2, counted from zero
      `SSP_MODE_M_ADD: half_len = {1'b0, cfg.clock_divider_value, 1'b1};
      default: half_len = `SSP_HALF_DIV4;
    endcase
  end
  // Tick from timer match edges or the half-period counter
  assign tick = (cfg.port_mode_code == `SSP_MODE_M_TMR2) ?
                (tm_toggle != tm_toggle_d) : (half_cnt == half_len);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      half_cnt <= 10'h000;
    else if (state == SSP_IDLE || tick)
      half_cnt <= 10'h000;
    else
      half_cnt <= half_cnt + 10'h001;
  end
  ////////////////////////////////////////////////////////////////
  // Shift engine: lead half then trail half per bit
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= SSP_IDLE;
      shift_register <= `SSP_BUF_RESET;
      bit_cnt <= 4'h0;
      sample_bit <= 1'b0;
      rx_push <= 1'b0;
    end
    else
    begin
      rx_push <= 1'b0;
      unique case (state)
        SSP_IDLE:
        begin
          // Master may start when software writes while wr_ready is high
          if (is_master && wr_strobe && wr_ready)
          begin
            shift_register <= wr_data;
            bit_cnt <= `SSP_BITS;
            state <= SSP_LEAD;
          end
        end
        SSP_LEAD:
        begin
          if (tick)
          begin
            // Middle-of-bit sample when phase bit clear
            // Limitation: the pin is seen two clocks late through the
            // synchroniser, so at the fastest rate only the end sample is safe
            if (!cfg.input_sample_phase_bit)
              sample_bit <= sdi_s2;
            state <= SSP_TRAIL;
          end
        end
        SSP_TRAIL:
        begin
          if (tick)
          begin
            // End-of-bit sample when phase bit set
            shift_register <= {shift_register[6:0],
                               cfg.input_sample_phase_bit ? sdi_s2 : sample_bit};
            bit_cnt <= bit_cnt - 4'h1;
            if (bit_cnt == 4'h1)
            begin
              rx_push <= 1'b1;
              state <= SSP_IDLE;
            end
            else
              state <= SSP_LEAD;
          end
        end
      endcase
    end
  end
  assign rx_byte = shift_register;
  ////////////////////////////////////////////////////////////////
  // Pin drive; edge bit set puts data out before first edge
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sck <= 1'b0;
      sdo <= 1'b0;
    end
    else
    begin
      if (state == SSP_IDLE)
        sck <= cfg.clock_polarity_bit;
      else if (state == SSP_LEAD)
        sck <= cfg.clock_polarity_bit ^ ~cfg.clock_edge_bit;
      else
        sck <= cfg.clock_polarity_bit ^ cfg.clock_edge_bit;
      // MSB first from the shifter
      sdo <= (state == SSP_IDLE) ? 1'b0 : shift_register[7];
    end
  end
  // Output can be released for receive-only use
  assign sdo_oe = is_master && !sdo_out_disable;
  ////////////////////////////////////////////////////////////////
  // Receive buffer; a full buffer holds off new writes
  ssp_buf2 #(.WIDTH(BUF_WIDTH)) u_rxbuf (
    .clk(clk),
    .nrst(nrst),
    .in_valid(rx_push),
    .in_ready(rx_in_ready),
    .in_data(rx_byte),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_out)
  );
  // Next write allowed only with room, so no byte is dropped
  assign wr_ready = (state == SSP_IDLE) && rx_in_ready && !rx_push;
  // Buffer register mirrors head of receive queue
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      xfer_buffer <= `SSP_BUF_RESET;
    else
      xfer_buffer <= rx_valid ? rx_out : xfer_buffer;
  end
  // Status; done flag is set on completion, set wins over pop
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      status <= '0;
    else
    begin
      status.busy <= (state != SSP_IDLE);
      status.rx_full <= rx_valid;
      status.overflow <= 1'b0;
      if (rx_push)
        status.done_flag <= 1'b1;
      else if (rx_valid && rx_ready)
        status.done_flag <= 1'b0;
    end
  end
endmodule

// file: verification/ssp_slave_model.sv
/*
  Behavioural SPI slave on the far side of the master.
  Assumes the bench loads its byte before each frame starts.
*/
`timescale 1ns/1ps
module ssp_slave_model (
  input wire logic sck,
  input wire logic sdo,
  input wire logic pol,
  input wire logic cke,
  input wire logic busy,
  input wire logic load,
  input wire logic [7:0] tx,
  output logic sdi,
  output logic [7:0] rx
);
  int n = 8; // Bits taken this frame, 8 means idle
  logic [7:0] sh;
  initial sdi = 1'b0;
  // New frame: top bit shown before any clock edge
  always @(posedge load)
  begin
    n = 0;
    sh = tx;
    sdi = tx[7];
  end
  // Released line shows the inverse, never a stale bit
  always @(negedge busy)
    if (n == 8)
      sdi = ~sdi;
  // Take on one edge, shift on the other, top bit first
  always @(sck)
    if (n < 8)
    begin
      if ((sck != pol) == cke)
      begin
        rx = {rx[6:0], sdo};
        n = n + 1;
      end
      else if (n > 0)
      begin
        sh = sh << 1;
        sdi = sh[7];
      end
    end
endmodule

// file: verification/ssp_spi_monitor.sv
/*
  Port checker for the SPI master.
  Assumes a bind onto ssp_spi_master and one clock domain.
*/
`timescale 1ns/1ps
module ssp_spi_monitor
  import ssp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire ssp_cfg_t cfg,
  input wire logic enable,
  input wire logic wr_strobe,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] xfer_buffer,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic wr_ready,
  input wire ssp_stat_t status,
  input wire ssp_fam_t mode_family,
  input wire logic slave_select_used,
  input wire logic i2c_ten_bit,
  input wire logic i2c_start_stop_irq,
  input wire logic i2c_master,
  input wire logic i2c_firmware,
  input wire logic tmr2_match,
  input wire logic sdi,
  input wire logic sck,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic sdo_out_disable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [4:0] edges; // Clock toggles since the last accepted write
  logic prev_sck;
  wire go = wr_strobe && wr_ready && enable && mode_family == SSP_FAM_MASTER;
  // Toggle seen this cycle counts at once, so a late busy fall still sees 16
  wire [4:0] tot = edges + {4'h0, sck ^ prev_sck};
  ////////////////////////////////////////////////////////////////
  // Toggle counter, restarted by each accepted write
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      edges <= 5'h00;
      prev_sck <= 1'b0;
    end
    else
    begin
      prev_sck <= sck;
      edges <= go ? 5'h00 : tot;
    end
  ////////////////////////////////////////////////////////////////
  no_overflow_a: assert property (status.overflow == 1'b0)
    else $error("overflow flag set in master mode");
  write_starts_a: assert property (go |-> ##[1:2] status.busy)
    else $error("accepted write started no transfer");
  refused_write_a: assert property (wr_strobe && !status.busy && !go |=> !status.busy)
    else $error("refused write started a transfer");
  idle_clock_a: assert property (!status.busy [*3] ##0 $stable(cfg.clock_polarity_bit)
    |-> sck == cfg.clock_polarity_bit)
    else $error("serial clock not at idle level");
  eight_bits_a: assert property ($fell(status.busy) |-> tot == 5'h10)
    else $error("frame did not have sixteen clock toggles");
  rx_pushed_a: assert property ($fell(status.busy) |-> ##[0:3] (rx_valid && status.done_flag))
    else $error("received byte not queued");
  queue_kept_a: assert property (rx_valid && !rx_ready |=> rx_valid)
    else $error("queued byte dropped while stalled");
  // Buffer register trails the queue head by one clock, so stability is checked after that
  rx_held_a: assert property ((rx_valid && !rx_ready) ##1 (rx_valid && !rx_ready)
    |=> $stable(xfer_buffer))
    else $error("queued byte lost while stalled");
  data_leads_a: assert property ((status.busy && cfg.clock_edge_bit
    && sck == cfg.clock_polarity_bit) ##1 (sck != cfg.clock_polarity_bit) |-> $stable(sdo))
    else $error("output changed on the leading clock edge");
  out_enable_a: assert property (sdo_oe == (mode_family == SSP_FAM_MASTER && enable
    && !sdo_out_disable))
    else $error("output enable wrong");
  select_used_a: assert property (slave_select_used == (cfg.port_mode_code == 4'h4))
    else $error("slave select decode wrong");
  master_codes_a: assert property ((cfg.port_mode_code <= 4'h3 || cfg.port_mode_code == 4'ha)
    |-> mode_family == SSP_FAM_MASTER)
    else $error("master code not decoded as master");
  ten_bit_a: assert property (i2c_ten_bit == (cfg.port_mode_code inside {4'h7, 4'hf}))
    else $error("ten bit address decode wrong");
  cover property ($fell(status.busy) && cfg.clock_edge_bit);
  cover property (wr_strobe && rx_valid && !wr_ready);
  cover property ($fell(status.busy) && !sdo_oe);
endmodule
bind ssp_spi_master ssp_spi_monitor u_mon (.*);

// file: verification/tb.sv
/*
  Self-checking bench for the SPI master with a slave model.
  Assumes the checker binds itself from its own file.
*/
`timescale 1ns/1ps
module tb;
  import ssp_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, enable = 1'b1, wr_strobe = 1'b0, rx_ready = 1'b0;
  logic tmr2_match = 1'b0, sdo_out_disable = 1'b0, load = 1'b0;
  logic [7:0] wr_data = 8'h00, ptx = 8'h00, xfer_buffer, prx;
  ssp_cfg_t cfg = '0;
  ssp_stat_t status;
  ssp_fam_t mode_family;
  logic rx_valid, wr_ready, slave_select_used, i2c_ten_bit, i2c_start_stop_irq;
  logic i2c_master, i2c_firmware, sdi, sck, sdo, sdo_oe, sck_q = 1'b0;
  int fails = 0, compares = 0, cyc = 0, t_last = 0, half = 0;
  // Mode, polarity/edge/phase, divider (never 0 for code a), master byte, slave byte
  // Fastest rate uses the end sample: the middle one falls in the synchroniser delay
  logic [30:0] rows [6] = '{{4'h0, 3'h1, 8'h00, 8'ha5, 8'h3c}, {4'h1, 3'h4, 8'h00, 8'h81, 8'h7e},
    {4'h2, 3'h2, 8'h00, 8'h5a, 8'hc3}, {4'h3, 3'h7, 8'h00, 8'h0f, 8'hf0},
    {4'ha, 3'h3, 8'h03, 8'h96, 8'h69}, {4'ha, 3'h4, 8'h01, 8'hff, 8'h00}};
  always #10 clk = ~clk;
  ssp_spi_master u_dut (.*);
  ssp_slave_model u_slave (.sck(sck), .sdo(sdo), .pol(cfg.clock_polarity_bit),
    .cke(cfg.clock_edge_bit), .busy(status.busy), .load(load), .tx(ptx), .sdi(sdi), .rx(prx));
  ////////////////////////////////////////////////////////////////
  // Timer match every 5 clocks, so its half period is 5
  always @(negedge clk) tmr2_match <= (cyc % 5 == 0);
  // Last gap between clock toggles, plus hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    sck_q <= sck;
    if (sck !== sck_q)
    begin
      half <= cyc - t_last;
      t_last <= cyc;
    end
    if (cyc == 20000)
    begin
      fails++;
      conclude();
    end
  end
  function automatic int exp_half(input logic [3:0] m, input logic [7:0] d);
    case (m)
      4'h0: return 2;
      4'h1: return 8;
      4'h2: return 32;
      4'h3: return 5;
      default: return 2 * d + 2;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One exchange; returns once the byte should be queued
  task automatic xfer(input logic [7:0] d, input logic [7:0] s);
    // Slave byte settles a clock before its load strobe, so the model never races it
    ptx = s;
    @(negedge clk);
    while (!wr_ready) @(negedge clk);
    load = 1'b1;
    wr_data = d;
    wr_strobe = 1'b1;
    @(negedge clk);
    load = 1'b0;
    wr_strobe = 1'b0;
    repeat (2) @(negedge clk);
    while (status.busy) @(negedge clk);
    repeat (3) @(negedge clk);
  endtask
  task automatic pop(input logic [7:0] e);
    chk({rx_valid, xfer_buffer}, {1'b1, e});
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
    // Buffer register follows the new queue head one clock later
    @(negedge clk);
  endtask
  task automatic refuse();
    wr_strobe = 1'b1;
    @(negedge clk);
    wr_strobe = 1'b0;
    repeat (2) @(negedge clk);
    chk(status.busy, 1'b0);
  endtask
  task automatic conclude();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(negedge clk);
    chk({status, xfer_buffer, sck, sdo}, 14'h0000);
    nrst = 1'b1;
    // Table rows: all clock sources and every polarity/edge pair
    for (int i = 0; i < 6; i++)
    begin
      cfg = rows[i][30:16];
      repeat (3) @(negedge clk);
      xfer(rows[i][15:8], rows[i][7:0]);
      chk(half, exp_half(cfg.port_mode_code, cfg.clock_divider_value));
      chk(prx, rows[i][15:8]);
      pop(rows[i][7:0]);
      $display("row %0d done", i);
    end
    // Receive only, output pin released
    sdo_out_disable = 1'b1;
    @(negedge clk);
    chk(sdo_oe, 1'b0);
    xfer(8'h00, 8'hb7);
    pop(8'hb7);
    sdo_out_disable = 1'b0;
    $display("receive only done");
    // Full buffer refuses the next write and never overflows
    xfer(8'h12, 8'h34);
    xfer(8'h56, 8'h78);
    chk({wr_ready, status.overflow}, 2'b00);
    refuse();
    pop(8'h34);
    pop(8'h78);
    chk(rx_valid, 1'b0);
    $display("buffer full done");
    // I2C codes see a legal divider and released pins
    cfg.clock_divider_value = 8'h03;
    sdo_out_disable = 1'b1;
    // Non-master codes decode and ignore writes; reserved ones skipped
    for (int c = 4; c < 16; c++)
      if (!(c inside {9, 10, 12, 13}))
      begin
        cfg.port_mode_code = 4'(c);
        @(negedge clk);
        chk(mode_family, c < 6 ? SSP_FAM_SLAVE : SSP_FAM_I2C);
        chk({slave_select_used, i2c_firmware, i2c_master}, {c == 4, c == 11, c == 8});
        chk({i2c_ten_bit, i2c_start_stop_irq}, {c == 7 || c == 15, c > 13});
        refuse();
      end
    cfg.port_mode_code = 4'h0;
    sdo_out_disable = 1'b0;
    enable = 1'b0;
    refuse();
    $display("decode done");
    // Reset in mid-frame: pins and status fall back, next exchange is whole
    cfg = rows[2][30:16];
    enable = 1'b1;
    wr_data = 8'hc3;
    wr_strobe = 1'b1;
    @(negedge clk);
    wr_strobe = 1'b0;
    repeat (20) @(negedge clk);
    chk(status.busy, 1'b1);
    nrst = 1'b0;
    @(negedge clk);
    chk({status, xfer_buffer, sck, sdo}, 14'h0000);
    nrst = 1'b1;
    xfer(8'h3a, 8'h5c);
    chk(prx, 8'h3a);
    pop(8'h5c);
    $display("mid reset done");
    conclude();
  end
endmodule
